/* File: hdl/logic_cluster.sv */
// logic cluster of ten cells with clock selection, clear/preset control and register access
//
// Notes on behaviour
// - ten cells; 26 external inputs plus ten feedback lines from own cells.
// - a cell's lookup result can feed the next cell's lookup directly.
// - carry passes to the right neighbour in the row, never across rows.
// - each cell output reaches own cluster and both neighbours, thirty cells.
// - four global clocks in; each cluster picks at most two of them.
// - every register has clear and preset; preset loads a one.
// - clear and preset together leave the register cleared.
// - cluster-wide controls: two clears and one preset.
// - enabled device-wide clear held low clears every register, above all else.
// - with device-wide clear disabled the pin is a plain input/output.
// - registers start at zero; on reload a per-register option loads one instead.
`timescale 1ns/1ps
module logic_cluster
  import cluster_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [3:0] gclk,
  input wire logic [25:0] ext_in,
  input wire logic [9:0] left_cells,
  input wire logic [9:0] right_cells,
  input wire logic carry_in,
  input wire logic device_wide_clear_n_in,
  output logic device_wide_clear_n_out,
  output logic device_wide_clear_n_oe,
  output logic [9:0] cell_out_q,
  output logic carry_out_q
);
  logic [31:0] ctrl_q;
  logic [9:0] cell_clk_q;
  logic [9:0] cell_clr_q;
  logic [9:0] cell_pre_q;
  logic [9:0] powerup_q;
  logic [31:0] cfg_q [NUM_CELLS];
  logic reload_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_held_q;
  logic w_held_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [3:0] gclk_s1_q;
  logic [3:0] gclk_s2_q;
  logic [3:0] gclk_prev_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_oe_q;
  logic pin_out_q;
  logic [3:0] gclk_rise;
  logic edge_a;
  logic edge_b;
  logic devclr_active;
  logic wr_go;
  logic wr_hit;
  logic [CFG_IDX_W-1:0] wr_idx;
  logic [31:0] rd_d;
  logic [1:0] rresp_d;
  logic [NUM_SRC-1:0] src;
  logic [9:0] edge_vec;
  logic [9:0] clr_vec;
  logic [9:0] pre_vec;
  logic [9:0] lut_vec;
  logic [9:0] reg_vec;
  logic [9:0] out_vec;
  logic [10:0] carry_vec;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = data[8*i +: 8];
    end
    return res;
  endfunction

  function automatic logic is_cfg(input logic [7:0] addr);
    return (addr[7:6] == ADDR_CFG_BASE[7:6]) && (addr[5:2] < 4'(NUM_CELLS));
  endfunction

  function automatic logic is_rw(input logic [7:0] addr);
    return (addr[7:2] == ADDR_CTRL[7:2]) || (addr[7:2] == ADDR_CELL_CLK[7:2]) ||
           (addr[7:2] == ADDR_CELL_CLR[7:2]) || (addr[7:2] == ADDR_CELL_PRE[7:2]) ||
           (addr[7:2] == ADDR_POWERUP[7:2]) || is_cfg(addr);
  endfunction

  // write channel: address and data accepted in either order, response after both
  assign wr_go = aw_held_q && w_held_q && !bvalid_q;
  assign wr_hit = wr_go && is_rw(awaddr_q);
  assign wr_idx = awaddr_q[5:2];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      awready_q <= 1'b1;
      awaddr_q <= 8'h00;
    end
    else if (awvalid && awready_q)
    begin
      aw_held_q <= 1'b1;
      awready_q <= 1'b0;
      awaddr_q <= awaddr;
    end
    else if (bvalid_q && bready)
    begin
      aw_held_q <= 1'b0;
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q <= 1'b0;
      wready_q <= 1'b1;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else if (wvalid && wready_q)
    begin
      w_held_q <= 1'b1;
      wready_q <= 1'b0;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end
    else if (bvalid_q && bready)
    begin
      w_held_q <= 1'b0;
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= is_rw(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid_q <= 1'b0;
  end

  // control registers; reload is a one-cycle pulse and reads back as zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= CTRL_RST;
      cell_clk_q <= CELL_VEC_RST;
      cell_clr_q <= CELL_VEC_RST;
      cell_pre_q <= CELL_VEC_RST;
      powerup_q <= CELL_VEC_RST;
      reload_q <= 1'b0;
    end
    else
    begin
      reload_q <= 1'b0;
      if (wr_hit && awaddr_q[7:2] == ADDR_CTRL[7:2])
      begin
        ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & CTRL_WMASK;
        reload_q <= wstrb_q[1] && wdata_q[CTRL_RELOAD];
      end
      if (wr_hit && awaddr_q[7:2] == ADDR_CELL_CLK[7:2])
        cell_clk_q <= 10'(merge({22'h0, cell_clk_q}, wdata_q, wstrb_q));
      if (wr_hit && awaddr_q[7:2] == ADDR_CELL_CLR[7:2])
        cell_clr_q <= 10'(merge({22'h0, cell_clr_q}, wdata_q, wstrb_q));
      if (wr_hit && awaddr_q[7:2] == ADDR_CELL_PRE[7:2])
        cell_pre_q <= 10'(merge({22'h0, cell_pre_q}, wdata_q, wstrb_q));
      if (wr_hit && awaddr_q[7:2] == ADDR_POWERUP[7:2])
        powerup_q <= 10'(merge({22'h0, powerup_q}, wdata_q, wstrb_q));
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NUM_CELLS; i++)
        cfg_q[i] <= CFG_RST;
    end
    else if (wr_hit && is_cfg(awaddr_q))
      cfg_q[wr_idx] <= merge(cfg_q[wr_idx], wdata_q, wstrb_q);
  end

  // read channel: one access at a time, data one cycle after the address
  always_comb
  begin
    rd_d = 32'h0000_0000;
    rresp_d = RESP_OKAY;
    if (is_cfg(araddr))
      rd_d = cfg_q[araddr[5:2]];
    else
    begin
      case (araddr[7:2])
        ADDR_CTRL[7:2]: rd_d = ctrl_q;
        ADDR_CELL_CLK[7:2]: rd_d = {22'h0, cell_clk_q};
        ADDR_CELL_CLR[7:2]: rd_d = {22'h0, cell_clr_q};
        ADDR_CELL_PRE[7:2]: rd_d = {22'h0, cell_pre_q};
        ADDR_POWERUP[7:2]: rd_d = {22'h0, powerup_q};
        ADDR_STATUS[7:2]: rd_d = {16'h0, gclk_s2_q, devclr_active, pin_s2_q, reg_vec};
        default: rresp_d = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else if (arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_d;
      rresp_q <= rresp_d;
    end
    else if (rvalid_q && rready)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // global clocks and the device-wide clear pin come from outside aclk
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gclk_s1_q <= 4'h0;
      gclk_s2_q <= 4'h0;
      gclk_prev_q <= 4'h0;
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
    end
    else
    begin
      gclk_s1_q <= gclk;
      gclk_s2_q <= gclk_s1_q;
      gclk_prev_q <= gclk_s2_q;
      pin_s1_q <= device_wide_clear_n_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign gclk_rise = gclk_s2_q & ~gclk_prev_q;
  assign edge_a = gclk_rise[ctrl_q[CTRL_SEL_A_LSB +: GSEL_W]];
  assign edge_b = gclk_rise[ctrl_q[CTRL_SEL_B_LSB +: GSEL_W]];
  assign devclr_active = ctrl_q[CTRL_DEVCLR_EN] && !pin_s2_q;

  // pin is driven as an output only while its clearing function is disabled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_oe_q <= 1'b0;
      pin_out_q <= 1'b0;
    end
    else
    begin
      pin_oe_q <= ctrl_q[CTRL_PIN_OE] && !ctrl_q[CTRL_DEVCLR_EN];
      pin_out_q <= ctrl_q[CTRL_PIN_OUT];
    end
  end

  assign device_wide_clear_n_oe = pin_oe_q;
  assign device_wide_clear_n_out = pin_out_q;

  // local interconnect sources: external, own feedback, left and right links
  assign src = {right_cells, left_cells, cell_out_q, ext_in};
  // first cluster of a row starts its carry at zero so chains stay in one row
  assign carry_vec[0] = ctrl_q[CTRL_ROW_FIRST] ? 1'b0 : carry_in;

  genvar g;
  generate
    for (g = 0; g < NUM_CELLS; g++)
    begin : cells
      logic sel_a_bit;
      logic sel_b_bit;
      logic [SRC_W-1:0] sa;
      logic [SRC_W-1:0] sb;
      assign sa = cfg_q[g][CFG_SEL_A_LSB +: SRC_W];
      assign sb = cfg_q[g][CFG_SEL_B_LSB +: SRC_W];
      assign sel_a_bit = (sa < SRC_W'(NUM_SRC)) ? src[sa] : 1'b0;
      assign sel_b_bit = (sb < SRC_W'(NUM_SRC)) ? src[sb] : 1'b0;
      assign edge_vec[g] = cell_clk_q[g] ? edge_b : edge_a;
      assign clr_vec[g] = cell_clr_q[g] ? ctrl_q[CTRL_CLEAR1] : ctrl_q[CTRL_CLEAR0];
      assign pre_vec[g] = cell_pre_q[g] && ctrl_q[CTRL_PRESET];
      logic_cell u_cell (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg_q[g]),
        .in_a(sel_a_bit),
        .in_b(sel_b_bit),
        .chain_in((g == 0) ? 1'b0 : lut_vec[(g == 0) ? 0 : g - 1]),
        .carry_in(carry_vec[g]),
        .clk_edge(edge_vec[g]),
        .clear(clr_vec[g]),
        .preset(pre_vec[g]),
        .dev_clear(devclr_active),
        .reload(reload_q),
        .powerup_high(powerup_q[g]),
        .lut_out(lut_vec[g]),
        .carry_out(carry_vec[g+1]),
        .reg_q(reg_vec[g]),
        .cell_out(out_vec[g])
      );
    end
  endgenerate

  // outputs to neighbours are registered, which also keeps feedback loop-free
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cell_out_q <= 10'h000;
      carry_out_q <= 1'b0;
    end
    else
    begin
      cell_out_q <= out_vec;
      carry_out_q <= carry_vec[NUM_CELLS];
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  clear_wins_a: assert property (clr_vec[0] && pre_vec[0] |=> !reg_vec[0])
    else $error("clear did not win over preset");
  devclr_all_a: assert property (devclr_active |=> reg_vec == 10'h000)
    else $error("device-wide clear left a register set");
  devclr_pin_a: assert property (!ctrl_q[CTRL_DEVCLR_EN] |-> !devclr_active)
    else $error("disabled clear pin acted as reset");
  preset_one_a: assert property (pre_vec[0] && !clr_vec[0] && !devclr_active
    |=> reg_vec[0])
    else $error("preset did not load one");
  capture_edge_a: assert property (edge_vec[0] && !devclr_active && !clr_vec[0]
    && !pre_vec[0] && !reload_q |=> reg_vec[0] == $past(lut_vec[0]))
    else $error("register missed its clock edge");
  reload_init_a: assert property (reload_q && !devclr_active && clr_vec == 10'h000
    && pre_vec == 10'h000 |=> reg_vec == $past(powerup_q))
    else $error("power-up value not loaded");
  // first in row: cell 0 carries only from its own operands, never from carry_in
  row_carry_a: assert property (ctrl_q[CTRL_ROW_FIRST] |-> carry_vec[1] ==
    (cfg_q[0][CFG_ARITH] && cells[0].sel_a_bit && cells[0].sel_b_bit))
    else $error("carry crossed into a new row");
  clock_sel_a: assert property (edge_vec[0] && !cell_clk_q[0]
    |-> $rose(gclk_s2_q[ctrl_q[CTRL_SEL_A_LSB +: GSEL_W]]))
    else $error("cell clocked without its selected clock");
  write_resp_a: assert property (awvalid && awready && wvalid && wready
    |=> ##1 bvalid)
    else $error("write response late");

  devclr_c: cover property (devclr_active ##1 !devclr_active);
  clear_preset_c: cover property (clr_vec[0] && pre_vec[0]);
  reload_c: cover property (reload_q && powerup_q != 10'h000);
  carry_out_c: cover property (carry_out_q);
endmodule

/* File: hdl/cluster_pkg.sv */
// constants for the logic cluster model and its register map
package cluster_pkg;
  localparam int NUM_CELLS = 10;
  localparam int NUM_EXT = 26;
  localparam int NUM_GCLK = 4;
  localparam int NUM_SRC = 56;
  localparam int SRC_W = 6;
  localparam int GSEL_W = 2;
  localparam int CFG_IDX_W = 4;
  localparam int ADDR_W = 8;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CELL_CLK = 8'h04;
  localparam logic [7:0] ADDR_CELL_CLR = 8'h08;
  localparam logic [7:0] ADDR_CELL_PRE = 8'h0c;
  localparam logic [7:0] ADDR_POWERUP = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_CFG_BASE = 8'h40;

  // control register fields
  localparam int CTRL_DEVCLR_EN = 0;
  localparam int CTRL_PIN_OUT = 1;
  localparam int CTRL_PIN_OE = 2;
  localparam int CTRL_CLEAR0 = 3;
  localparam int CTRL_CLEAR1 = 4;
  localparam int CTRL_PRESET = 5;
  localparam int CTRL_SEL_A_LSB = 6;
  localparam int CTRL_SEL_B_LSB = 8;
  localparam int CTRL_ROW_FIRST = 10;
  localparam int CTRL_RELOAD = 11;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_07ff;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [9:0] CELL_VEC_RST = 10'h000;

  // per-cell configuration word fields
  localparam int CFG_MASK_LSB = 0;
  localparam int CFG_SEL_A_LSB = 16;
  localparam int CFG_SEL_B_LSB = 22;
  localparam int CFG_CHAIN = 28;
  localparam int CFG_ARITH = 29;
  localparam int CFG_BYPASS = 30;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;

  // status register fields
  localparam int STAT_PIN = 10;
  localparam int STAT_DEVCLR = 11;
  localparam int STAT_GCLK_LSB = 12;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: hdl/logic_cell.sv */
// one logic cell: four-input lookup table, carry logic and a register with clear and preset
`timescale 1ns/1ps
module logic_cell
  import cluster_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] cfg,
  input wire logic in_a,
  input wire logic in_b,
  input wire logic chain_in,
  input wire logic carry_in,
  input wire logic clk_edge,
  input wire logic clear,
  input wire logic preset,
  input wire logic dev_clear,
  input wire logic reload,
  input wire logic powerup_high,
  output logic lut_out,
  output logic carry_out,
  output logic reg_q,
  output logic cell_out
);
  logic in_c;
  logic in_d;
  logic [15:0] mask;

  assign mask = cfg[CFG_MASK_LSB +: 16];
  assign in_c = cfg[CFG_CHAIN] ? chain_in : 1'b0;
  assign in_d = cfg[CFG_ARITH] ? carry_in : 1'b0;
  assign lut_out = mask[{in_d, in_c, in_b, in_a}];
  assign carry_out = cfg[CFG_ARITH] &
    ((in_a & in_b) | (in_a & carry_in) | (in_b & carry_in));
  assign cell_out = cfg[CFG_BYPASS] ? lut_out : reg_q;

  // controls act at the next aclk edge regardless of the cluster clock,
  // standing in for the truly asynchronous paths of the fabric
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reg_q <= 1'b0;
    else if (dev_clear)
      reg_q <= 1'b0;
    else if (clear)
      reg_q <= 1'b0;
    else if (preset)
      reg_q <= 1'b1;
    else if (reload)
      reg_q <= powerup_high;
    else if (clk_edge)
      reg_q <= lut_out;
  end
endmodule

/* File: testbench/neighbour_model.sv */
// neighbour clusters and the outside driver of the device-wide clear pin
`timescale 1ns/1ps
module neighbour_model (
  input wire logic aclk,
  input wire logic [9:0] left_set,
  input wire logic [9:0] right_set,
  input wire logic carry_set,
  input wire logic clear_hold,
  output logic [9:0] left_cells,
  output logic [9:0] right_cells,
  output logic carry_in,
  output logic pin_pull_low
);
  // neighbours show registered cell outputs, so they move only after a clock edge
  always @(posedge aclk)
  begin
    left_cells <= left_set;
    right_cells <= right_set;
    carry_in <= carry_set;
  end
  // only ever pulls low; the board pull-up supplies the released level
  assign pin_pull_low = clear_hold;
endmodule

/* File: testbench/tb_logic_cluster.sv */
// self-checking bench for the logic cluster: register bus tasks and cell scenarios
`timescale 1ns/1ps
module tb_logic_cluster;
  import cluster_pkg::*;
  logic aclk, aresetn;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, gclk;
  logic [1:0] bresp, rresp;
  logic [25:0] ext_in;
  logic [9:0] left_cells, right_cells, left_set, right_set, cell_out_q;
  logic carry_in, carry_set, clear_hold, pull_low, carry_out_q;
  logic pin, pin_out, pin_oe;
  int errors, n_tests;
  localparam logic [31:0] CFGW [7] = '{32'h0000_aaaa, 32'h1000_f0f0, 32'h0024_aaaa,
    32'h0019_aaaa, 32'h0037_aaaa, 32'h0000_cccc, 32'h001a_aaaa};

  // pull-up on the pin unless someone drives it
  assign pin = pin_oe ? pin_out : (pull_low ? 1'b0 : 1'b1);

  logic_cluster logic_cluster_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .gclk(gclk), .ext_in(ext_in), .left_cells(left_cells),
    .right_cells(right_cells), .carry_in(carry_in), .device_wide_clear_n_in(pin),
    .device_wide_clear_n_out(pin_out), .device_wide_clear_n_oe(pin_oe),
    .cell_out_q(cell_out_q), .carry_out_q(carry_out_q));

  neighbour_model neighbour_model_i (.aclk(aclk), .left_set(left_set), .right_set(right_set),
    .carry_set(carry_set), .clear_hold(clear_hold), .left_cells(left_cells),
    .right_cells(right_cells), .carry_in(carry_in), .pin_pull_low(pull_low));

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic wrap_up();
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    n_tests++;
    if ((got & m) !== (exp & m))
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got & m, exp & m);
    end
  endtask

  // write one word; each channel is released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    logic done;
    done = 1'b0;
    r = 2'b11;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // the wait ends on bvalid; it has no timeout of its own, only the watchdog
    while (!done)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        done = 1'b1;
        r = bresp;
        bready <= 1'b0;
      end
    end
    chk({30'h0, r}, {30'h0, er}, 32'h3);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    logic done;
    done = 1'b0;
    r = 2'b11;
    d = 32'hx;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        done = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    chk(d, exp, m);
    chk({30'h0, r}, {30'h0, er}, 32'h3);
  endtask

  task automatic pulse(input int i);
    gclk[i] <= 1'b1;
    repeat (6) @(posedge aclk);
    gclk[i] <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask

  initial
  begin
    #(25 * 20000);
    errors++;
    wrap_up();
  end

  initial
  begin
    errors = 0;
    n_tests = 0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    gclk = 4'h0;
    ext_in = 26'h0;
    left_set = 10'h000;
    right_set = 10'h000;
    carry_set = 1'b0;
    clear_hold = 1'b1;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL, CTRL_RST, 32'hffff_ffff, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0, 32'h3ff, RESP_OKAY);
    rd(8'h30, 32'h0, 32'hffff_ffff, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h3ff, RESP_SLVERR);
    // pin held low throughout, clear function still disabled
    wr(ADDR_CELL_PRE, 32'h3ff, RESP_OKAY);
    wr(ADDR_CTRL, 32'h20, RESP_OKAY);
    rd(ADDR_STATUS, 32'h3ff, 32'h3ff, RESP_OKAY);
    chk({22'h0, cell_out_q}, 32'h3ff, 32'h3ff);
    wr(ADDR_CTRL, 32'h28, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0, 32'h3ff, RESP_OKAY);
    wr(ADDR_CELL_CLR, 32'h00f, RESP_OKAY);
    wr(ADDR_CTRL, 32'h30, RESP_OKAY);
    rd(ADDR_STATUS, 32'h3f0, 32'h3ff, RESP_OKAY);
    wr(ADDR_CTRL, 32'h28, RESP_OKAY);
    rd(ADDR_STATUS, 32'h00f, 32'h3ff, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    wr(ADDR_POWERUP, 32'h155, RESP_OKAY);
    wr(ADDR_CTRL, 32'h800, RESP_OKAY);
    rd(ADDR_STATUS, 32'h155, 32'hfff, RESP_OKAY);
    rd(ADDR_CTRL, 32'h0, 32'hffff_ffff, RESP_OKAY);
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    rd(ADDR_STATUS, 32'h800, 32'hfff, RESP_OKAY);
    wr(ADDR_CTRL, 32'h21, RESP_OKAY);
    rd(ADDR_STATUS, 32'h800, 32'hfff, RESP_OKAY);
    clear_hold <= 1'b0;
    repeat (6) @(posedge aclk);
    rd(ADDR_STATUS, 32'h7ff, 32'hfff, RESP_OKAY);
    wr(ADDR_CTRL, 32'h04, RESP_OKAY);
    // pin drive follows the control register one edge later
    @(posedge aclk);
    chk({30'h0, pin_oe, pin_out}, 32'h2, 32'h3);
    rd(ADDR_STATUS, 32'h3ff, 32'h7ff, RESP_OKAY);
    wr(ADDR_CTRL, 32'h05, RESP_OKAY);
    @(posedge aclk);
    chk({31'h0, pin_oe}, 32'h0, 32'h1);
    wr(ADDR_CTRL, 32'h18, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0, 32'h3ff, RESP_OKAY);
    // clock A is global clock 2, clock B global clock 3; cell 5 runs on B
    wr(ADDR_CTRL, 32'h380, RESP_OKAY);
    wr(ADDR_CELL_CLK, 32'h020, RESP_OKAY);
    for (int i = 0; i < 7; i++)
      wr(ADDR_CFG_BASE + 8'(4 * i), CFGW[i], RESP_OKAY);
    rd(ADDR_CFG_BASE + 8'h04, CFGW[1], 32'hffff_ffff, RESP_OKAY);
    ext_in <= 26'h200_0001;
    left_set <= 10'h001;
    right_set <= 10'h200;
    pulse(1);
    rd(ADDR_STATUS, 32'h0, 32'h3ff, RESP_OKAY);
    pulse(2);
    rd(ADDR_STATUS, 32'h01f, 32'h3ff, RESP_OKAY);
    pulse(3);
    rd(ADDR_STATUS, 32'h03f, 32'h3ff, RESP_OKAY);
    pulse(2);
    rd(ADDR_STATUS, 32'h07f, 32'h3ff, RESP_OKAY);
    chk({22'h0, cell_out_q}, 32'h07f, 32'h3ff);
    // every cell propagates carry: operand a is ext_in[25] high, operand b an unused source
    for (int i = 0; i < NUM_CELLS; i++)
      wr(ADDR_CFG_BASE + 8'(4 * i), 32'h2fd9_0000, RESP_OKAY);
    carry_set <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({31'h0, carry_out_q}, 32'h1, 32'h1);
    wr(ADDR_CTRL, 32'h780, RESP_OKAY);
    @(posedge aclk);
    chk({31'h0, carry_out_q}, 32'h0, 32'h1);
    wrap_up();
  end
endmodule
